// [lfd_coef_dec.sv]
module lfd_coef_dec #(
    parameter int MANT_W = 17,
    parameter int EXP_W = 5,
    parameter int BASE = 17,
    parameter bit NEGATE = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Stored fields
    input wire logic [MANT_W-1:0] mant,
    input wire logic [EXP_W-1:0] expf,
    // Effective coefficient
    output lfd_pkg::lfd_coef_t coef
);

    wire logic signed [lfd_pkg::MANT_OUT_W-1:0] mag;
    wire logic signed [lfd_pkg::MANT_OUT_W-1:0] mant_next;
    wire logic signed [lfd_pkg::EXP_OUT_W-1:0] exp_next;

    assign mag = lfd_pkg::MANT_OUT_W'(mant);
    assign mant_next = NEGATE ? -mag : mag;
    assign exp_next = -(lfd_pkg::EXP_OUT_W'(BASE) + lfd_pkg::EXP_OUT_W'(expf));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coef <= '0;
        end else begin
            coef <= '{mant: mant_next, exp: exp_next};
        end
    end

endmodule

// [lfd_frac_div.sv]
module lfd_frac_div #(
    parameter int NUM_W = 10,
    parameter int FRAC_W = 24
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Request
    input wire logic start,
    input wire logic [NUM_W-1:0] num,
    input wire logic [NUM_W-1:0] den,
    // Result
    output logic busy,
    output logic done,
    output logic den_zero,
    output logic [NUM_W+FRAC_W-1:0] quot
);

    localparam int Q_W = NUM_W + FRAC_W;
    localparam int CNT_W = $clog2(Q_W + 1);

    logic [Q_W-1:0] dvd_reg;
    logic [NUM_W:0] rem_reg;
    logic [NUM_W-1:0] den_reg;
    logic [NUM_W-1:0] num_reg;
    logic [CNT_W-1:0] cnt_reg;

    wire logic [NUM_W:0] rem_shift;
    wire logic fits;
    wire logic [NUM_W:0] rem_sub;
    wire logic [Q_W+NUM_W-1:0] check_val;
    wire logic [Q_W+NUM_W-1:0] check_ref;

    assign rem_shift = {rem_reg[NUM_W-1:0], dvd_reg[Q_W-1]};
    assign fits = rem_shift >= {1'b0, den_reg};
    assign rem_sub = fits ? rem_shift - {1'b0, den_reg} : rem_shift;
    assign check_val = (Q_W+NUM_W)'(quot) * (Q_W+NUM_W)'(den_reg) + (Q_W+NUM_W)'(rem_reg);
    assign check_ref = (Q_W+NUM_W)'({num_reg, {FRAC_W{1'b0}}});

    // ------------------------------------------------------------
    // Restoring long division of num * 2^FRAC_W by den
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dvd_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
            num_reg <= '0;
            cnt_reg <= '0;
            quot <= '0;
            busy <= 1'b0;
            done <= 1'b0;
            den_zero <= 1'b0;
        end else if (start) begin
            dvd_reg <= {num, {FRAC_W{1'b0}}};
            rem_reg <= '0;
            den_reg <= den;
            num_reg <= num;
            cnt_reg <= CNT_W'(Q_W);
            quot <= '0;
            busy <= (den != '0);
            done <= (den == '0);
            den_zero <= (den == '0);
        end else if (busy) begin
            dvd_reg <= {dvd_reg[Q_W-2:0], 1'b0};
            rem_reg <= rem_sub;
            quot <= {quot[Q_W-2:0], fits};
            cnt_reg <= cnt_reg - 1'b1;
            busy <= (cnt_reg != CNT_W'(1));
            done <= (cnt_reg == CNT_W'(1));
        end else begin
            done <= 1'b0;
        end
    end

    a_div_exact: assert property (@(posedge pclk) disable iff (!presetn)
        done && !den_zero |-> check_val == check_ref)
        else $error("Fraction quotient does not match numerator over denominator.");

    a_div_bounded: assert property (@(posedge pclk) disable iff (!presetn)
        start |-> ##[1:40] done)
        else $error("Fraction division did not finish in time.");

endmodule

// [lfd_pkg.sv]
package lfd_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_ALPHA = 8'h00;
    localparam logic [7:0] ADDR_BETA = 8'h04;
    localparam logic [7:0] ADDR_GAMMA = 8'h08;
    localparam logic [7:0] ADDR_DELTA = 8'h0C;
    localparam logic [7:0] ADDR_FB_INT = 8'h10;
    localparam logic [7:0] ADDR_FB_FRAC = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    localparam logic [7:0] ADDR_EXPS = 8'h1C;
    localparam logic [7:0] ADDR_RATIO_INT = 8'h20;
    localparam logic [7:0] ADDR_RATIO_FRAC = 8'h24;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int ALPHA_MANT_LSB = 0;
    localparam int ALPHA_MANT_W = 16;
    localparam int ALPHA_SHIFT_LSB = 16;
    localparam int ALPHA_SHIFT_W = 6;
    localparam int ALPHA_FGAIN_LSB = 22;
    localparam int ALPHA_FGAIN_W = 3;
    localparam int ALPHA_BGAIN_LSB = 25;
    localparam int ALPHA_BGAIN_W = 4;
    localparam int BG_MANT_W = 17;
    localparam int DELTA_MANT_W = 15;
    localparam int COEF_EXP_LSB = 24;
    localparam int COEF_EXP_W = 5;
    localparam int FB_INT_W = 20;
    localparam int FB_FRAC_W = 10;
    localparam int FB_NUM_LSB = 0;
    localparam int FB_DEN_LSB = 16;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DEN_ZERO_BIT = 1;
    localparam int STAT_VALID_BIT = 2;

    // ------------------------------------------------------------
    // Write masks and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] ALPHA_MASK = 32'h1FFF_FFFF;
    localparam logic [31:0] BG_MASK = 32'h1F01_FFFF;
    localparam logic [31:0] DELTA_MASK = 32'h1F00_7FFF;
    localparam logic [31:0] FB_INT_MASK = 32'h000F_FFFF;
    localparam logic [31:0] FB_FRAC_MASK = 32'h03FF_03FF;
    localparam logic [31:0] COEF_RST = 32'h0000_0001;
    localparam logic [31:0] FB_INT_RST = 32'h0000_0000;
    localparam logic [31:0] FB_FRAC_RST = 32'h0001_0000;

    // ------------------------------------------------------------
    // Decoding constants
    // ------------------------------------------------------------
    localparam int ALPHA_BASE = 16;
    localparam int BETA_BASE = 17;
    localparam int GAMMA_BASE = 17;
    localparam int DELTA_BASE = 15;
    localparam logic [20:0] DIV_INT_OFFSET = 21'h00_0001;
    localparam int FRAC_W = 24;
    localparam int RATIO_INT_W = 22;
    localparam int MANT_OUT_W = 18;
    localparam int EXP_OUT_W = 8;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic signed [MANT_OUT_W-1:0] mant;
        logic signed [EXP_OUT_W-1:0] exp;
    } lfd_coef_t;

    typedef struct packed {
        logic [RATIO_INT_W-1:0] int_part;
        logic [FRAC_W-1:0] frac_part;
    } lfd_ratio_t;

endpackage

// [lfd_top.sv]
// Summary of operation
// - Alpha is its unsigned mantissa times 2 to the minus 16 minus shift plus both gains.
// - The shift moves the binary point left; front gain scales input, back gain output.
// - Beta magnitude is its mantissa times 2 to the minus 17 minus the beta exponent field.
// - Gamma magnitude is its mantissa times 2 to the minus 17 minus the gamma exponent field.
// - Beta and gamma are stored as positive magnitudes and handed to the core as negatives.
// - The feedback ratio is the stored integer plus one plus numerator over denominator.
//
// The APB register port and the register addresses were decided locally.
module lfd_top #(
    parameter int NUM_W = 10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [lfd_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Effective coefficients for the loop filter core
    output lfd_pkg::lfd_coef_t alpha_coef,
    output lfd_pkg::lfd_coef_t beta_coef,
    output lfd_pkg::lfd_coef_t gamma_coef,
    output lfd_pkg::lfd_coef_t delta_coef,
    // Effective feedback divide ratio
    output lfd_pkg::lfd_ratio_t div_ratio,
    output logic ratio_valid
);

    localparam int Q_W = NUM_W + lfd_pkg::FRAC_W;
    localparam int RATIO_W = lfd_pkg::RATIO_INT_W + lfd_pkg::FRAC_W;

    function automatic logic addr_is(input logic [lfd_pkg::ADDR_W-1:0] a,
                                     input logic [7:0] off);
        addr_is = (a == off);
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [31:0] alpha_reg;
    logic [31:0] beta_reg;
    logic [31:0] gamma_reg;
    logic [31:0] delta_reg;
    logic [31:0] fb_int_reg;
    logic [31:0] fb_frac_reg;
    logic start_reg;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic setup;
    wire logic wr_en;
    wire logic sel_alpha;
    wire logic sel_beta;
    wire logic sel_gamma;
    wire logic sel_delta;
    wire logic sel_fb_int;
    wire logic sel_fb_frac;
    wire logic sel_status;
    wire logic sel_exps;
    wire logic sel_rint;
    wire logic sel_rfrac;
    wire logic addr_hit;
    wire logic [31:0] rd_data;
    wire logic [31:0] status_word;
    wire logic [31:0] exps_word;

    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;
    assign sel_alpha = addr_is(paddr, lfd_pkg::ADDR_ALPHA);
    assign sel_beta = addr_is(paddr, lfd_pkg::ADDR_BETA);
    assign sel_gamma = addr_is(paddr, lfd_pkg::ADDR_GAMMA);
    assign sel_delta = addr_is(paddr, lfd_pkg::ADDR_DELTA);
    assign sel_fb_int = addr_is(paddr, lfd_pkg::ADDR_FB_INT);
    assign sel_fb_frac = addr_is(paddr, lfd_pkg::ADDR_FB_FRAC);
    assign sel_status = addr_is(paddr, lfd_pkg::ADDR_STATUS);
    assign sel_exps = addr_is(paddr, lfd_pkg::ADDR_EXPS);
    assign sel_rint = addr_is(paddr, lfd_pkg::ADDR_RATIO_INT);
    assign sel_rfrac = addr_is(paddr, lfd_pkg::ADDR_RATIO_FRAC);
    assign addr_hit = sel_alpha || sel_beta || sel_gamma || sel_delta || sel_fb_int
        || sel_fb_frac || sel_status || sel_exps || sel_rint || sel_rfrac;

    // ------------------------------------------------------------
    // Divider status
    // ------------------------------------------------------------
    wire logic div_busy;
    wire logic div_done;
    wire logic div_den_zero;
    wire logic [Q_W-1:0] div_quot;

    assign status_word = {29'h0000_0000, ratio_valid, div_den_zero, div_busy};
    assign exps_word = {alpha_coef.exp, beta_coef.exp, gamma_coef.exp, delta_coef.exp};

    assign rd_data = sel_alpha ? alpha_reg :
                     sel_beta ? beta_reg :
                     sel_gamma ? gamma_reg :
                     sel_delta ? delta_reg :
                     sel_fb_int ? fb_int_reg :
                     sel_fb_frac ? fb_frac_reg :
                     sel_status ? status_word :
                     sel_exps ? exps_word :
                     sel_rint ? 32'(div_ratio.int_part) :
                     sel_rfrac ? 32'(div_ratio.frac_part) :
                     32'h0000_0000;

    // ------------------------------------------------------------
    // APB answer: one wait-free access phase after each setup
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup && !addr_hit;
            prdata <= (setup && !pwrite) ? rd_data : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Field registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alpha_reg <= lfd_pkg::COEF_RST;
            beta_reg <= lfd_pkg::COEF_RST;
            gamma_reg <= lfd_pkg::COEF_RST;
            delta_reg <= lfd_pkg::COEF_RST;
            fb_int_reg <= lfd_pkg::FB_INT_RST;
            fb_frac_reg <= lfd_pkg::FB_FRAC_RST;
        end else if (wr_en) begin
            if (sel_alpha) begin
                alpha_reg <= pwdata & lfd_pkg::ALPHA_MASK;
            end
            if (sel_beta) begin
                beta_reg <= pwdata & lfd_pkg::BG_MASK;
            end
            if (sel_gamma) begin
                gamma_reg <= pwdata & lfd_pkg::BG_MASK;
            end
            if (sel_delta) begin
                delta_reg <= pwdata & lfd_pkg::DELTA_MASK;
            end
            if (sel_fb_int) begin
                fb_int_reg <= pwdata & lfd_pkg::FB_INT_MASK;
            end
            if (sel_fb_frac) begin
                fb_frac_reg <= pwdata & lfd_pkg::FB_FRAC_MASK;
            end
        end
    end

    // ------------------------------------------------------------
    // Alpha decode
    // ------------------------------------------------------------
    wire logic [lfd_pkg::ALPHA_MANT_W-1:0] a_mant;
    wire logic [lfd_pkg::ALPHA_SHIFT_W-1:0] a_shift;
    wire logic [lfd_pkg::ALPHA_FGAIN_W-1:0] a_fgain;
    wire logic [lfd_pkg::ALPHA_BGAIN_W-1:0] a_bgain;
    wire logic signed [lfd_pkg::EXP_OUT_W-1:0] a_exp_next;

    assign a_mant = alpha_reg[lfd_pkg::ALPHA_MANT_LSB +: lfd_pkg::ALPHA_MANT_W];
    assign a_shift = alpha_reg[lfd_pkg::ALPHA_SHIFT_LSB +: lfd_pkg::ALPHA_SHIFT_W];
    assign a_fgain = alpha_reg[lfd_pkg::ALPHA_FGAIN_LSB +: lfd_pkg::ALPHA_FGAIN_W];
    assign a_bgain = alpha_reg[lfd_pkg::ALPHA_BGAIN_LSB +: lfd_pkg::ALPHA_BGAIN_W];
    // The mantissa is a 16-bit fraction; the shift lowers the exponent, both gains raise it.
    assign a_exp_next = -lfd_pkg::EXP_OUT_W'(lfd_pkg::ALPHA_BASE)
        - lfd_pkg::EXP_OUT_W'(a_shift)
        + lfd_pkg::EXP_OUT_W'(a_fgain)
        + lfd_pkg::EXP_OUT_W'(a_bgain);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alpha_coef <= '0;
        end else begin
            alpha_coef <= '{mant: lfd_pkg::MANT_OUT_W'(a_mant), exp: a_exp_next};
        end
    end

    // ------------------------------------------------------------
    // Beta, gamma and delta decode
    // ------------------------------------------------------------
    lfd_coef_dec #(
        .MANT_W(lfd_pkg::BG_MANT_W),
        .EXP_W(lfd_pkg::COEF_EXP_W),
        .BASE(lfd_pkg::BETA_BASE),
        .NEGATE(1'b1)
    ) u_beta (
        .pclk(pclk),
        .presetn(presetn),
        .mant(beta_reg[lfd_pkg::BG_MANT_W-1:0]),
        .expf(beta_reg[lfd_pkg::COEF_EXP_LSB +: lfd_pkg::COEF_EXP_W]),
        .coef(beta_coef)
    );

    lfd_coef_dec #(
        .MANT_W(lfd_pkg::BG_MANT_W),
        .EXP_W(lfd_pkg::COEF_EXP_W),
        .BASE(lfd_pkg::GAMMA_BASE),
        .NEGATE(1'b1)
    ) u_gamma (
        .pclk(pclk),
        .presetn(presetn),
        .mant(gamma_reg[lfd_pkg::BG_MANT_W-1:0]),
        .expf(gamma_reg[lfd_pkg::COEF_EXP_LSB +: lfd_pkg::COEF_EXP_W]),
        .coef(gamma_coef)
    );

    lfd_coef_dec #(
        .MANT_W(lfd_pkg::DELTA_MANT_W),
        .EXP_W(lfd_pkg::COEF_EXP_W),
        .BASE(lfd_pkg::DELTA_BASE),
        .NEGATE(1'b0)
    ) u_delta (
        .pclk(pclk),
        .presetn(presetn),
        .mant(delta_reg[lfd_pkg::DELTA_MANT_W-1:0]),
        .expf(delta_reg[lfd_pkg::COEF_EXP_LSB +: lfd_pkg::COEF_EXP_W]),
        .coef(delta_coef)
    );

    // ------------------------------------------------------------
    // Feedback ratio
    // ------------------------------------------------------------
    wire logic fb_write;
    wire logic [20:0] int_eff;
    wire logic [RATIO_W-1:0] ratio_sum;

    assign fb_write = wr_en && (sel_fb_int || sel_fb_frac);
    assign int_eff = 21'(fb_int_reg[lfd_pkg::FB_INT_W-1:0]) + lfd_pkg::DIV_INT_OFFSET;
    assign ratio_sum = {1'b0, int_eff, {lfd_pkg::FRAC_W{1'b0}}} + RATIO_W'(div_quot);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_reg <= 1'b1;
            div_ratio <= '0;
            ratio_valid <= 1'b0;
        end else begin
            start_reg <= fb_write;
            if (start_reg) begin
                ratio_valid <= 1'b0;
            end else if (div_done) begin
                div_ratio <= ratio_sum;
                ratio_valid <= 1'b1;
            end
        end
    end

    lfd_frac_div #(
        .NUM_W(NUM_W),
        .FRAC_W(lfd_pkg::FRAC_W)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_reg),
        .num(fb_frac_reg[lfd_pkg::FB_NUM_LSB +: NUM_W]),
        .den(fb_frac_reg[lfd_pkg::FB_DEN_LSB +: NUM_W]),
        .busy(div_busy),
        .done(div_done),
        .den_zero(div_den_zero),
        .quot(div_quot)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_alpha_exp: assert property (@(posedge pclk) disable iff (!presetn)
        $stable(alpha_reg) |=> alpha_coef.exp == -8'sd16 - $signed({2'b00, $past(a_shift)})
            + $signed({5'b00000, $past(a_fgain)}) + $signed({4'b0000, $past(a_bgain)}))
        else $error("Alpha exponent does not follow its fields.");

    a_alpha_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel_alpha |-> ##2 alpha_coef.mant == $signed({2'b00, $past(pwdata[15:0], 2)})
            && alpha_coef.exp == -8'sd16 - $signed({2'b00, $past(pwdata[21:16], 2)})
            + $signed({5'b00000, $past(pwdata[24:22], 2)})
            + $signed({4'b0000, $past(pwdata[28:25], 2)}))
        else $error("Alpha write did not reach the coefficient in two cycles.");

    a_beta_exp: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel_beta |-> ##2
            beta_coef.exp == -8'sd17 - $signed({3'b000, $past(pwdata[28:24], 2)}))
        else $error("Beta exponent wrong.");

    a_gamma_exp: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel_gamma |-> ##2
            gamma_coef.exp == -8'sd17 - $signed({3'b000, $past(pwdata[28:24], 2)}))
        else $error("Gamma exponent wrong.");

    a_bg_sign: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 $stable(beta_reg) && $stable(gamma_reg) |=>
            beta_coef.mant == -$signed({1'b0, $past(beta_reg[16:0])})
            && gamma_coef.mant == -$signed({1'b0, $past(gamma_reg[16:0])}))
        else $error("Beta or gamma not applied as a negative value.");

    a_delta_exp: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && sel_delta |-> ##2
            delta_coef.exp == -8'sd15 - $signed({3'b000, $past(pwdata[28:24], 2)})
            && delta_coef.mant == $signed({3'b000, $past(pwdata[14:0], 2)}))
        else $error("Delta decode wrong.");

    a_ratio_int: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(ratio_valid) && div_quot == '0 |->
            div_ratio.int_part == 22'(fb_int_reg[19:0]) + 22'h00_0001)
        else $error("Integer divide ratio is not the stored value plus one.");

    a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
        setup |=> pready ##1 !pready)
        else $error("APB access phase is not exactly one cycle.");

endmodule

// [lfd_top_tb_top.sv]
module lfd_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ------------------------------------------------------------
    // Signals and design
    // ------------------------------------------------------------
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    lfd_pkg::lfd_coef_t alpha_coef;
    lfd_pkg::lfd_coef_t beta_coef;
    lfd_pkg::lfd_coef_t gamma_coef;
    lfd_pkg::lfd_coef_t delta_coef;
    lfd_pkg::lfd_ratio_t div_ratio;
    logic ratio_valid;
    logic [31:0] rd;
    logic er;
    int n_fail = 0;
    int checks = 0;

    always #5 pclk = ~pclk;

    lfd_top #(.NUM_W(10)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .alpha_coef(alpha_coef),
        .beta_coef(beta_coef), .gamma_coef(gamma_coef), .delta_coef(delta_coef),
        .div_ratio(div_ratio), .ratio_valid(ratio_valid)
    );

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [45:0] got, input logic [45:0] exp, input string m);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %0h expected %0h", $time, m, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            $display("mismatch at %0t: no pready", $time);
            give_verdict();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, "read data");
        chk(er, err, "slave error");
    endtask

    task automatic wr_coef(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (2) @(posedge pclk);
        #1;
    endtask

    task automatic coef(input lfd_pkg::lfd_coef_t c, input int m, input int e);
        chk(c.mant, m, "coef mantissa");
        chk(c.exp, e, "coef exponent");
    endtask

    task automatic wait_ratio;
        int i;
        repeat (3) @(posedge pclk);
        for (i = 0; i < 100; i++) begin
            @(posedge pclk);
            #1;
            if (ratio_valid === 1'b1) break;
        end
        if (i == 100) begin
            n_fail++;
            $display("mismatch at %0t: ratio never valid", $time);
            give_verdict();
        end
    endtask

    task automatic ratio(input logic [31:0] s, u, v, input logic [21:0] ei, input logic [23:0] ef);
        apb(1'b1, lfd_pkg::ADDR_FB_INT, s);
        apb(1'b1, lfd_pkg::ADDR_FB_FRAC, (v << 16) | u);
        wait_ratio();
        chk(div_ratio.int_part, ei, "ratio integer");
        chk(div_ratio.frac_part, ef, "ratio fraction");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        #1;
        coef(alpha_coef, 1, -16);
        coef(beta_coef, -1, -17);
        coef(gamma_coef, -1, -17);
        coef(delta_coef, 1, -15);
        wait_ratio();
        chk(div_ratio.int_part, 1, "reset ratio");
        $display("test reset done");
        wr_coef(lfd_pkg::ADDR_ALPHA, 32'h0006_D0A8);
        coef(alpha_coef, 53416, -22);
        wr_coef(lfd_pkg::ADDR_ALPHA, 32'h1FC6_D0A8);
        coef(alpha_coef, 53416, 0);
        wr_coef(lfd_pkg::ADDR_BETA, 32'h0D01_250B);
        coef(beta_coef, -75019, -30);
        wr_coef(lfd_pkg::ADDR_GAMMA, 32'h0D01_3ABB);
        coef(gamma_coef, -80571, -30);
        wr_coef(lfd_pkg::ADDR_DELTA, 32'h0800_420A);
        coef(delta_coef, 16906, -23);
        wr_coef(lfd_pkg::ADDR_DELTA, 32'hFFFF_FFFF);
        coef(delta_coef, 32767, -46);
        rdchk(lfd_pkg::ADDR_DELTA, 32'h1F00_7FFF, 1'b0);
        wr_coef(lfd_pkg::ADDR_BETA, 32'hFFFF_FFFF);
        coef(beta_coef, -131071, -48);
        $display("test coefficients done");
        ratio(32'd5, 32'd1, 32'd4, 22'd6, 24'h40_0000);
        ratio(32'h000F_FFFF, 32'd1, 32'd2, 22'h10_0000, 24'h80_0000);
        ratio(32'd0, 32'd5, 32'd4, 22'd2, 24'h40_0000);
        ratio(32'd2, 32'd3, 32'd0, 22'd3, 24'h00_0000);
        rdchk(lfd_pkg::ADDR_STATUS, 32'h0000_0006, 1'b0);
        $display("test ratio done");
        rdchk(8'h28, 32'h0000_0000, 1'b1);
        rdchk(8'h02, 32'h0000_0000, 1'b1);
        apb(1'b1, 8'h30, 32'h0000_0000);
        chk(er, 1'b1, "write slave error");
        apb(1'b1, lfd_pkg::ADDR_RATIO_INT, 32'h0000_0000);
        rdchk(lfd_pkg::ADDR_RATIO_INT, 32'h0000_0003, 1'b0);
        rdchk(lfd_pkg::ADDR_ALPHA, 32'h1FC6_D0A8, 1'b0);
        rdchk(lfd_pkg::ADDR_EXPS, 32'h00D0_E2D2, 1'b0);
        $display("test access done");
        give_verdict();
    end
endmodule
